// ==== design/cnt_pulse.sv ====
// One-cycle trigger pulse when the period counter meets a target.
// Assumes counter and target on the same clock.
`timescale 1ns/1ps
module cnt_pulse #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Compare
  input  wire logic         en,
  input  wire logic [W-1:0] cnt,
  input  wire logic [W-1:0] at,
  // Trigger
  output logic              pulse_r
);

  wire logic hit = en && (cnt == at);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_r <= 1'b0;
    else
      pulse_r <= hit;
  end

endmodule : cnt_pulse

// ==== design/cnt_window.sv ====
// Level that sets at one counter target and clears at another.
// Clear wins on a tie, so equal targets give no pulse at all.
`timescale 1ns/1ps
module cnt_window #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Compare
  input  wire logic         en,
  input  wire logic [W-1:0] cnt,
  input  wire logic [W-1:0] set_at,
  input  wire logic [W-1:0] clr_at,
  // Level
  output logic              q_r
);

  wire logic set_hit = cnt == set_at;
  wire logic clr_hit = cnt == clr_at;
  wire logic q_nxt   = !en ? 1'b0 : clr_hit ? 1'b0 : set_hit ? 1'b1 : q_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_r <= 1'b0;
    else
      q_r <= q_nxt;
  end

endmodule : cnt_window

// ==== design/pwm_edges_pkg.sv ====
// Constants, register map and carrier types for the normal-mode edge generator.
// Assumes a 32-bit APB slave with word-aligned registers, 16-bit counts.
package pwm_edges_pkg;

  localparam int          CNT_W          = 16;
  localparam int          ADDR_W         = 8;
  localparam int          IDX_W          = 4;

  // Register indices; byte address is index times four
  localparam logic [3:0]  IDX_CTRL       = 4'h0;
  localparam logic [3:0]  IDX_PERIOD     = 4'h1;
  localparam logic [3:0]  IDX_EVENT1     = 4'h2;
  localparam logic [3:0]  IDX_EVENT2     = 4'h3;
  localparam logic [3:0]  IDX_EVENT3     = 4'h4;
  localparam logic [3:0]  IDX_EVENT4     = 4'h5;
  localparam logic [3:0]  IDX_ADAPT_OFS  = 4'h6;
  localparam logic [3:0]  IDX_PHASE      = 4'h7;
  localparam logic [3:0]  IDX_SAMPLE1    = 4'h8;
  localparam logic [3:0]  IDX_SAMPLE2    = 4'h9;
  localparam logic [3:0]  IDX_BLANKA_BEG = 4'ha;
  localparam logic [3:0]  IDX_BLANKA_END = 4'hb;
  localparam logic [3:0]  IDX_BLANKB_BEG = 4'hc;
  localparam logic [3:0]  IDX_BLANKB_END = 4'hd;
  localparam logic [3:0]  IDX_STATUS     = 4'he;
  localparam int          NUM_RW         = 14;

  // Control field positions
  localparam int          CTRL_ENABLE    = 0;
  localparam int          CTRL_ADAPT_B   = 1;
  localparam int          CTRL_PHASE_DUTY = 2;

  // Status field positions
  localparam int          STAT_CNT_LSB   = 16;

  // Reset values
  localparam logic [15:0] RST_ZERO       = 16'h0000;
  localparam logic [15:0] RST_PERIOD     = 16'h00ff;

  // Values sampled from the filter once per switching period
  typedef struct packed {
    logic [CNT_W-1:0] duty;
    logic [CNT_W-1:0] adj_a;
  } filt_s;

  // Edge targets for one period
  typedef struct packed {
    logic [CNT_W-1:0] a_rise;
    logic [CNT_W-1:0] a_fall;
    logic [CNT_W-1:0] b_rise;
    logic [CNT_W-1:0] b_fall;
    logic [CNT_W-1:0] adapt;
    logic [CNT_W-1:0] phase;
  } targets_s;

endpackage : pwm_edges_pkg

// ==== design/pwm_normal_mode_edges.sv ====
// Normal (trailing-edge) mode edge generator of one pulse modulator.
// Assumes an APB master on pclk and a compensation filter on the same clock.
`timescale 1ns/1ps

// Contract
// - The period counter counts from zero to the period limit, then restarts at zero.
// - Each signal changes in the cycle after the counter equals that signal's target.
// - The first switch output rises when the counter reaches Event 1.
// - The first switch output falls at Event 1 plus filter duty plus cycle adjust A.
// - Adaptive trigger option A fires at Event 1 plus duty plus the adaptive offset.
// - Adaptive trigger option B fires at Event 1 plus half the duty plus the offset.
// - The second switch output rises at the first output's fall plus Event 3 minus Event 2.
// - The second switch output falls when the counter reaches Event 4.
// - The phase trigger comes from its register or from the filter duty, as configured.
// - Sample triggers 1 and 2 and blanking windows A and B come straight from registers.
// - Cycle adjust B is ignored and moves no edge.
module pwm_normal_mode_edges (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Compensation filter
  input  wire logic [15:0] filter_duty,
  input  wire logic [15:0] cycle_adj_a,
  input  wire logic [15:0] cycle_adj_b,
  // Modulator outputs
  output logic             first_switch_output,
  output logic             second_switch_output,
  output logic             adaptive_trigger,
  output logic             sample_trigger_1,
  output logic             sample_trigger_2,
  output logic             blank_a,
  output logic             blank_b,
  output logic             phase_trigger,
  output logic             period_start
);

  localparam int W = pwm_edges_pkg::CNT_W;

  // Register file
  logic [W-1:0]  regs_r [pwm_edges_pkg::NUM_RW];
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;

  // Counter and per-period filter sample
  logic [W-1:0]  cnt_r;
  logic [W-1:0]  cnt_nxt;
  logic          start_r;
  pwm_edges_pkg::filt_s    filt_r;
  pwm_edges_pkg::filt_s    filt_nxt;
  pwm_edges_pkg::targets_s tgt;

  // APB decode
  wire logic [3:0] idx      = paddr[5:2];
  wire logic       setup    = psel && !penable;
  wire logic       access   = psel && penable && pready_r;
  wire logic       mapped   = idx <= pwm_edges_pkg::IDX_STATUS;
  wire logic       wr_ok    = access && pwrite && mapped && (idx != pwm_edges_pkg::IDX_STATUS);
  wire logic [W-1:0] wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Named register fields
  wire logic [W-1:0] ctrl      = regs_r[pwm_edges_pkg::IDX_CTRL];
  wire logic [W-1:0] period    = regs_r[pwm_edges_pkg::IDX_PERIOD];
  wire logic [W-1:0] event1    = regs_r[pwm_edges_pkg::IDX_EVENT1];
  wire logic [W-1:0] event2    = regs_r[pwm_edges_pkg::IDX_EVENT2];
  wire logic [W-1:0] event3    = regs_r[pwm_edges_pkg::IDX_EVENT3];
  wire logic [W-1:0] event4    = regs_r[pwm_edges_pkg::IDX_EVENT4];
  wire logic [W-1:0] adapt_ofs = regs_r[pwm_edges_pkg::IDX_ADAPT_OFS];
  wire logic [W-1:0] phase_reg = regs_r[pwm_edges_pkg::IDX_PHASE];
  wire logic         en        = ctrl[pwm_edges_pkg::CTRL_ENABLE];
  wire logic         adapt_b   = ctrl[pwm_edges_pkg::CTRL_ADAPT_B];
  wire logic         ph_duty   = ctrl[pwm_edges_pkg::CTRL_PHASE_DUTY];

  // Read mux
  wire logic [31:0] status = {cnt_r, 8'h00, period_start, phase_trigger, blank_b,
                              blank_a, adaptive_trigger, second_switch_output,
                              first_switch_output, en};
  wire logic [31:0] rd_word = !mapped ? 32'h0000_0000 :
                              (idx == pwm_edges_pkg::IDX_STATUS) ? status :
                              {16'h0000, regs_r[idx]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < pwm_edges_pkg::NUM_RW; i++)
        regs_r[i] <= pwm_edges_pkg::RST_ZERO;
      regs_r[pwm_edges_pkg::IDX_PERIOD] <= pwm_edges_pkg::RST_PERIOD;
    end
    else if (wr_ok)
      regs_r[idx] <= (regs_r[idx] & ~wmask) | (pwdata[W-1:0] & wmask);
  end

  // Zero wait: read data is fetched in setup so it stands from a flop in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite)
        prdata_r <= rd_word;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Period counter
  wire logic wrap = cnt_r >= period;
  assign cnt_nxt  = (!en || wrap) ? '0 : W'(cnt_r + 1'b1);

  // Filter values are latched at the wrap so edges stay put within a period
  assign filt_nxt = (!en || wrap)
                  ? pwm_edges_pkg::filt_s'{duty: filter_duty, adj_a: cycle_adj_a}
                  : filt_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r   <= '0;
      filt_r  <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      filt_r  <= filt_nxt;
      start_r <= en && wrap;
    end
  end

  assign period_start = start_r;

  // Edge targets; sums wrap at counter width
  assign tgt.a_rise = event1;
  assign tgt.a_fall = W'(event1 + filt_r.duty + filt_r.adj_a);
  assign tgt.b_rise = W'(tgt.a_fall + event3 - event2);
  assign tgt.b_fall = event4;
  assign tgt.adapt  = adapt_b ? W'(event1 + (filt_r.duty >> 1) + adapt_ofs)
                              : W'(event1 + filt_r.duty + adapt_ofs);
  assign tgt.phase  = ph_duty ? filt_r.duty : phase_reg;
  // Cycle adjust B feeds no target in this mode

  // Switch outputs and blanking windows
  cnt_window #(.W(W)) u_first (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .set_at (tgt.a_rise),
    .clr_at (tgt.a_fall),
    .q_r    (first_switch_output)
  );

  cnt_window #(.W(W)) u_second (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .set_at (tgt.b_rise),
    .clr_at (tgt.b_fall),
    .q_r    (second_switch_output)
  );

  cnt_window #(.W(W)) u_blank_a (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .set_at (regs_r[pwm_edges_pkg::IDX_BLANKA_BEG]),
    .clr_at (regs_r[pwm_edges_pkg::IDX_BLANKA_END]),
    .q_r    (blank_a)
  );

  cnt_window #(.W(W)) u_blank_b (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .set_at (regs_r[pwm_edges_pkg::IDX_BLANKB_BEG]),
    .clr_at (regs_r[pwm_edges_pkg::IDX_BLANKB_END]),
    .q_r    (blank_b)
  );

  // Triggers
  cnt_pulse #(.W(W)) u_adapt (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .at     (tgt.adapt),
    .pulse_r(adaptive_trigger)
  );

  cnt_pulse #(.W(W)) u_sample1 (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .at     (regs_r[pwm_edges_pkg::IDX_SAMPLE1]),
    .pulse_r(sample_trigger_1)
  );

  cnt_pulse #(.W(W)) u_sample2 (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .at     (regs_r[pwm_edges_pkg::IDX_SAMPLE2]),
    .pulse_r(sample_trigger_2)
  );

  cnt_pulse #(.W(W)) u_phase (
    .pclk   (pclk),
    .presetn(presetn),
    .en     (en),
    .cnt    (cnt_r),
    .at     (tgt.phase),
    .pulse_r(phase_trigger)
  );

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cnt_wrap: assert property (en && cnt_r >= period |=> cnt_r == '0)
    else $error("counter did not wrap at period limit");

  a_cnt_step: assert property (en && cnt_r < period ##1 en |-> cnt_r == W'($past(cnt_r) + 1'b1))
    else $error("counter did not step by one");

  a_first_rise: assert property (
    en && cnt_r == tgt.a_rise && tgt.a_fall != tgt.a_rise |=> first_switch_output)
    else $error("first output missed its rise");

  a_first_fall: assert property (en && cnt_r == tgt.a_fall |=> !first_switch_output)
    else $error("first output missed its fall");

  a_second_rise: assert property (
    en && cnt_r == tgt.b_rise && tgt.b_fall != tgt.b_rise |=> second_switch_output)
    else $error("second output missed its rise");

  a_second_fall: assert property (en && cnt_r == event4 |=> !second_switch_output)
    else $error("second output missed its fall");

  a_first_hold: assert property (
    $rose(first_switch_output) |-> $past(cnt_r) == $past(event1))
    else $error("first output rose away from its target");

  a_second_hold: assert property (
    $rose(second_switch_output) |-> $past(cnt_r) == $past(tgt.b_rise))
    else $error("second output rose away from its target");

  a_period_mark: assert property (
    period_start |-> $past(en) && $past(cnt_r) >= $past(period))
    else $error("period start away from the wrap");

  a_adapt_pos: assert property (adaptive_trigger |-> $past(en) &&
    $past(cnt_r) == W'($past(event1) + ($past(adapt_b) ? ($past(filt_r.duty) >> 1)
                                          : $past(filt_r.duty)) + $past(adapt_ofs)))
    else $error("adaptive trigger off target");

  a_phase_src: assert property (phase_trigger |->
    $past(cnt_r) == ($past(ph_duty) ? $past(filt_r.duty) : $past(phase_reg)))
    else $error("phase trigger off target");

  a_sample_one: assert property (sample_trigger_1 |->
    $past(cnt_r) == $past(regs_r[pwm_edges_pkg::IDX_SAMPLE1]))
    else $error("sample trigger 1 off target");

  a_sample_two: assert property (sample_trigger_2 |->
    $past(cnt_r) == $past(regs_r[pwm_edges_pkg::IDX_SAMPLE2]))
    else $error("sample trigger 2 off target");

  a_blank_a_beg: assert property ($rose(blank_a) |->
    $past(cnt_r) == $past(regs_r[pwm_edges_pkg::IDX_BLANKA_BEG]))
    else $error("blanking window A opened off target");

  a_adj_b_ignored: assert property (en && $changed(cycle_adj_b) && $stable(cycle_adj_a)
    && $stable(filter_duty) && !wrap && !wr_ok |=> $stable(tgt.b_rise))
    else $error("cycle adjust B moved an edge");

  c_wrap: cover property (en && wrap ##[1:300] first_switch_output);
  c_both: cover property (first_switch_output ##[1:100] second_switch_output);
  c_adapt_b: cover property (adapt_b && adaptive_trigger);
  c_read: cover property (access && !pwrite && !pslverr);

endmodule : pwm_normal_mode_edges

// ==== verification/filter_model.sv ====
// Compensation filter stand-in: registered duty and cycle adjusts.
// Assumes the bench sets wanted values right after a clock edge.
`timescale 1ns/1ps
module filter_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Wanted values
  input  wire logic [15:0] duty_in,
  input  wire logic [15:0] adja_in,
  input  wire logic [15:0] adjb_in,
  // To the modulator
  output logic [15:0]      filter_duty,
  output logic [15:0]      cycle_adj_a,
  output logic [15:0]      cycle_adj_b
);
  // Registered, so values never move in the sampling step
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {filter_duty, cycle_adj_a, cycle_adj_b} <= '0;
    else
      {filter_duty, cycle_adj_a, cycle_adj_b} <= {duty_in, adja_in, adjb_in};
endmodule : filter_model

// ==== verification/tb_pwm_normal_mode_edges.sv ====
// Self-checking bench for the normal-mode edge generator.
// Assumes the filter model on the far side; APB is driven here.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_pwm_normal_mode_edges;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] duty_in, adja_in, adjb_in, fd, fa, fb;
  logic        fso, sso, adt, pht, st1, st2, bla, blb, pst;
  logic [8:0]  obs, prv;
  int          n_mismatch, check_count, cyc, e, rise[9], fall[9], wv[6];
  typedef struct {
    int e1, e2, e3, e4, ofs, ph, duty, adja, adjb, ctrl, x_fa, x_rb, x_ad, x_ph;
  } row_s;
  // Inputs, then expected fall A, rise B, adaptive and phase counts
  row_s rows[3] = '{
    '{2, 4, 7, 40, 1, 20, 10, 0, 0, 1, 12, 15, 13, 20},
    '{3, 5, 9, 42, 2, 20, 11, 2, 65535, 3, 16, 20, 10, 20},
    '{1, 2, 3, 38, 0, 25, 9, 1, 7, 7, 11, 12, 5, 9}};

  assign obs = {pst, blb, bla, st2, st1, pht, adt, sso, fso};

  filter_model filt_u (.pclk(pclk), .presetn(presetn), .duty_in(duty_in),
    .adja_in(adja_in), .adjb_in(adjb_in), .filter_duty(fd), .cycle_adj_a(fa),
    .cycle_adj_b(fb));

  pwm_normal_mode_edges dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filter_duty(fd), .cycle_adj_a(fa), .cycle_adj_b(fb),
    .first_switch_output(fso), .second_switch_output(sso), .adaptive_trigger(adt),
    .sample_trigger_1(st1), .sample_trigger_2(st2), .blank_a(bla), .blank_b(blb),
    .phase_trigger(pht), .period_start(pst));

  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // One transfer; an idle edge after it keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 16)
      n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (fso !== v && n < 200)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 200)
      n_mismatch++;
  endtask : wait_lvl

  // Offsets of every edge from the first output's rise, second period on
  task automatic measure();
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    prv = obs;
    for (int i = 0; i < 9; i++)
    begin
      rise[i] = -1;
      fall[i] = -1;
    end
    for (int k = 1; k < 67; k++)
    begin
      @(posedge pclk);
      // Late filter change must not move this period's edges
      if (k == 2)
        duty_in <= 16'h0020;
      if (k == 5)
        adjb_in <= 16'hbeef;
      for (int i = 0; i < 9; i++)
      begin
        if (!prv[i] && obs[i] && rise[i] < 0)
          rise[i] = k;
        if (prv[i] && !obs[i] && fall[i] < 0)
          fall[i] = k;
      end
      prv = obs;
    end
  endtask : measure

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {duty_in, adja_in, adjb_in} = '0;
    repeat (5) @(posedge pclk);
    `CHK(obs, 9'h000)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h000000ff)
    $display("test end: reset values");
    wv = '{63, 30, 45, 8, 12, 50};
    apb(1'b1, 8'h04, 32'(wv[0]));
    for (int j = 1; j < 6; j++)
      apb(1'b1, 8'(28 + 4 * j), 32'(wv[j]));
    apb(1'b1, 8'h34, 32'd55);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h00, 32'h0);
      duty_in <= 16'(rows[i].duty);
      adja_in <= 16'(rows[i].adja);
      adjb_in <= 16'(rows[i].adjb);
      wv = '{rows[i].e1, rows[i].e2, rows[i].e3, rows[i].e4, rows[i].ofs, rows[i].ph};
      for (int j = 0; j < 6; j++)
        apb(1'b1, 8'(8 + 4 * j), 32'(wv[j]));
      apb(1'b1, 8'h00, 32'(rows[i].ctrl));
      measure();
      e = rows[i].e1;
      `CHK(rise[0], 64)
      `CHK(rise[8], 63 - e)
      `CHK(rise[0] - rise[8], e + 1)
      `CHK(fall[0], rows[i].x_fa - e)
      `CHK(rise[1], rows[i].x_rb - e)
      `CHK(fall[1], rows[i].e4 - e)
      `CHK(rise[2], rows[i].x_ad - e)
      `CHK(rise[3], rows[i].x_ph - e)
      `CHK(rise[4], 30 - e)
      `CHK(rise[5], 45 - e)
      `CHK(rise[6], 8 - e)
      `CHK(fall[6], 12 - e)
      `CHK(rise[7], 50 - e)
      `CHK(fall[7], 55 - e)
      for (int k = 2; k < 9; k = (k == 5) ? 8 : k + 1)
        `CHK(fall[k] - rise[k], 1)
      $display("test end: row %0d", i);
    end
    apb(1'b1, 8'h3c, 32'h1234);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h38, 32'hffff);
    `CHK(err, 1'b0)
    pstrb <= 4'h1;
    apb(1'b1, 8'h0c, 32'habcd);
    pstrb <= 4'hf;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h000000cd)
    $display("test end: bus refusals");
    apb(1'b1, 8'h00, 32'h0);
    @(posedge pclk);
    `CHK(obs, 9'h000)
    apb(1'b0, 8'h38, 32'h0);
    `CHK(rd[31:16], 16'h0000)
    apb(1'b1, 8'h00, 32'h1);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(obs, 9'h000)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h000000ff)
    $display("test end: disable and reset");
    finish_test();
  end
endmodule : tb_pwm_normal_mode_edges
